//--- core/usc1_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Byte-wide register port, one register per address
// Notes:   Included by bare name
`ifndef USC1_DEFINES_SVH
`define USC1_DEFINES_SVH

`define USC1_ADDR_STATUS   3'h0
`define USC1_ADDR_CTRL1    3'h1
`define USC1_ADDR_CTRL2    3'h2
`define USC1_ADDR_DATA     3'h3
`define USC1_ADDR_DIVL     3'h4
`define USC1_ADDR_DIVH     3'h5

// Status fields
`define USC1_ST_PERR       7
`define USC1_ST_NOISE      6
`define USC1_ST_FERR       5
`define USC1_ST_OVR        4
`define USC1_ST_RXIDLE     3
`define USC1_ST_RXAV       2
`define USC1_ST_TXIDLE     1
`define USC1_ST_TXEMPTY    0
`define USC1_STATUS_RST    8'h0B

// Control one fields
`define USC1_C1_PORT_ON    7
`define USC1_C1_NINE       6
`define USC1_C1_PAR_ON     5
`define USC1_C1_KIND_HI    4
`define USC1_C1_KIND_LO    3
`define USC1_C1_BREAK      2
`define USC1_C1_RX9        1
`define USC1_C1_TX9        0

// Control two fields
`define USC1_C2_TX_ON      7
`define USC1_C2_RX_ON      6
`define USC1_C2_STOP2      5
`define USC1_C2_RX_IRQ     2

`define USC1_DIV_RST       16'h0010
`define USC1_BREAK_BITS    4'hD

`endif

//--- core/usc1_pkg.sv
// Purpose: Types shared by the serial port status/control block
// Assumes: Nothing
// Notes:   One-hot state encodings
package usc1_pkg;

  typedef enum logic [4:0] {
    USC1_TX_IDLE  = 5'b0_0001,
    USC1_TX_START = 5'b0_0010,
    USC1_TX_DATA  = 5'b0_0100,
    USC1_TX_STOP  = 5'b0_1000,
    USC1_TX_BREAK = 5'b1_0000
  } usc1_tx_state_t;

  typedef enum logic [3:0] {
    USC1_RX_IDLE  = 4'b0001,
    USC1_RX_START = 4'b0010,
    USC1_RX_DATA  = 4'b0100,
    USC1_RX_STOP  = 4'b1000
  } usc1_rx_state_t;

  typedef enum logic [1:0] {
    USC1_PAR_EVEN  = 2'b00,
    USC1_PAR_ODD   = 2'b01,
    USC1_PAR_MARK  = 2'b10,
    USC1_PAR_SPACE = 2'b11
  } usc1_par_kind_t;

endpackage

//--- core/usc1_top.sv
// Purpose: Serial port status flags, control one, framing engine
// Assumes: Registers written/read by one-cycle strobes from the CPU
// Notes:   Read data valid the cycle after the read strobe
//
// Functional notes
// - Parity mismatch sets parity error flag
// - Error flags clear by status read, data access
// - Noise flag with data-available, not on overrun
// - Bad stop bit sets framing error flag
// - Overrun flag set, blocks further receive transfers
// - Receiver idle low from start to stop
// - Data-available set at FIFO trigger level
// - Word errors flagged with data-available same cycle when RX_TRIGGER is 1
// - Data-available clears: status, data read, empty
// - Transmit idle when empty, nothing sending, pin high
// - Transmit idle clears: status read, data write
// - Transmit empty set on shifter load, cleared likewise
// - Enabling transmitter sets transmit empty
// - Port off: pins float, buffers emptied, baud reset
// - Port off clears transmit/receive enables, error and data-available flags; sets idle and empty flags
// - Port off aborts frames, configuration retained
// - Word length selects 8 or 9 bits
// - Parity bit not copied into received data
// - Parity kinds even, odd, mark, space
// - Break: finish data, low 13 bits minimum
// - Received ninth read-only, transmit ninth write-only
// - Status read-only, idle and empty reset high
// - Bits shifted LSB first at baud rate
// - Receive interrupt from overrun or data-available
`timescale 1ns/1ps
`include "usc1_defines.svh"

module usc1_top
  import usc1_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int RX_TRIGGER = 1
) (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       rx_pin_i,
  output logic            tx_pin_o,
  output logic            tx_pin_oe_o,
  output logic            irq_o
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam logic [PW:0] TRIG = (PW+1)'(RX_TRIGGER);
  localparam logic [PW:0] FULL = (PW+1)'(FIFO_DEPTH);

  function automatic logic par_calc(input logic [8:0] d, input logic nine,
                                    input logic [1:0] kind);
    logic ones;
    ones = nine ? ^d[7:0] : ^d[6:0];
    case (kind)
      USC1_PAR_EVEN: par_calc = ones;
      USC1_PAR_ODD:  par_calc = ~ones;
      USC1_PAR_MARK: par_calc = 1'b1;
      default:       par_calc = 1'b0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register state and access decode
  logic        port_on_q, nine_q, par_on_q, brk_q, tx9_q;
  logic [1:0]  kind_q;
  logic        tx_on_q, rx_on_q, stop2_q, rx_irq_q;
  logic [15:0] div_q;
  logic        perr_q, noise_q, ferr_q, ovr_q, rx_idle_q, rx_av_q;
  logic        tx_idle_q, tx_empty_q;
  logic        err_arm_q, rxav_arm_q, tx_arm_q;

  logic st_rd, data_rd, data_wr, c1_wr, c2_wr;
  assign st_rd   = reg_rd_i && reg_addr_i == `USC1_ADDR_STATUS;
  assign data_rd = reg_rd_i && reg_addr_i == `USC1_ADDR_DATA;
  assign data_wr = reg_wr_i && reg_addr_i == `USC1_ADDR_DATA;
  assign c1_wr   = reg_wr_i && reg_addr_i == `USC1_ADDR_CTRL1;
  assign c2_wr   = reg_wr_i && reg_addr_i == `USC1_ADDR_CTRL2;

  // Receive FIFO
  logic [8:0]  fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  logic [PW:0] count_q;
  logic        push, pop;
  logic [8:0]  push_word;
  logic        word_perr, word_ferr, word_noise, frame_done;

  assign pop = data_rd && count_q != '0;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_on_q <= 1'b0;
      nine_q    <= 1'b0;
      par_on_q  <= 1'b0;
      kind_q    <= 2'b00;
      brk_q     <= 1'b0;
      tx9_q     <= 1'b0;
    end else if (c1_wr) begin
      port_on_q <= reg_wdata_i[`USC1_C1_PORT_ON];
      nine_q    <= reg_wdata_i[`USC1_C1_NINE];
      par_on_q  <= reg_wdata_i[`USC1_C1_PAR_ON];
      kind_q    <= reg_wdata_i[`USC1_C1_KIND_HI:`USC1_C1_KIND_LO];
      brk_q     <= reg_wdata_i[`USC1_C1_BREAK] &&
                   reg_wdata_i[`USC1_C1_PORT_ON];
      tx9_q     <= reg_wdata_i[`USC1_C1_TX9];
    end else if (!port_on_q) begin
      brk_q     <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_on_q  <= 1'b0;
      rx_on_q  <= 1'b0;
      stop2_q  <= 1'b0;
      rx_irq_q <= 1'b0;
    end else begin
      if (c2_wr) begin
        stop2_q  <= reg_wdata_i[`USC1_C2_STOP2];
        rx_irq_q <= reg_wdata_i[`USC1_C2_RX_IRQ];
      end
      if (!port_on_q) begin
        tx_on_q <= 1'b0;
        rx_on_q <= 1'b0;
      end else if (c2_wr) begin
        tx_on_q <= reg_wdata_i[`USC1_C2_TX_ON];
        rx_on_q <= reg_wdata_i[`USC1_C2_RX_ON];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= `USC1_DIV_RST;
    end else if (reg_wr_i && reg_addr_i == `USC1_ADDR_DIVL) begin
      div_q[7:0] <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == `USC1_ADDR_DIVH) begin
      div_q[15:8] <= reg_wdata_i;
    end
  end

  // Read data, status is never written
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `USC1_ADDR_STATUS) begin
        reg_rdata_o <= {perr_q, noise_q, ferr_q, ovr_q,
                        rx_idle_q, rx_av_q, tx_idle_q, tx_empty_q};
      end else if (reg_addr_i == `USC1_ADDR_CTRL1) begin
        reg_rdata_o <= {port_on_q, nine_q, par_on_q, kind_q, brk_q,
                        fifo_mem[rd_ptr_q][8], 1'b0};
      end else if (reg_addr_i == `USC1_ADDR_CTRL2) begin
        reg_rdata_o <= {tx_on_q, rx_on_q, stop2_q, 2'b00, rx_irq_q, 2'b00};
      end else if (reg_addr_i == `USC1_ADDR_DATA) begin
        reg_rdata_o <= fifo_mem[rd_ptr_q][7:0];
      end else if (reg_addr_i == `USC1_ADDR_DIVL) begin
        reg_rdata_o <= div_q[7:0];
      end else if (reg_addr_i == `USC1_ADDR_DIVH) begin
        reg_rdata_o <= div_q[15:8];
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clearing sequences: status read arms, data access clears
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_arm_q  <= 1'b0;
      rxav_arm_q <= 1'b0;
      tx_arm_q   <= 1'b0;
    end else if (st_rd) begin
      err_arm_q  <= 1'b1;
      rxav_arm_q <= rx_av_q;
      tx_arm_q   <= tx_empty_q || tx_idle_q;
    end else if (data_rd || data_wr) begin
      err_arm_q  <= 1'b0;
      rxav_arm_q <= 1'b0;
      tx_arm_q   <= 1'b0;
    end
  end

  logic err_clr;
  assign err_clr = err_arm_q && (data_rd || data_wr);

  // Error flags; a new event wins over the clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      perr_q  <= 1'b0;
      noise_q <= 1'b0;
      ferr_q  <= 1'b0;
      ovr_q   <= 1'b0;
    end else if (!port_on_q) begin
      perr_q  <= 1'b0;
      noise_q <= 1'b0;
      ferr_q  <= 1'b0;
      ovr_q   <= 1'b0;
    end else begin
      if (push && word_perr) perr_q <= 1'b1;
      else if (err_clr) perr_q <= 1'b0;
      if (push && word_noise) noise_q <= 1'b1;
      else if (err_clr) noise_q <= 1'b0;
      if (push && word_ferr) ferr_q <= 1'b1;
      else if (err_clr) ferr_q <= 1'b0;
      if (frame_done && (ovr_q || count_q == FULL)) ovr_q <= 1'b1;
      else if (err_clr) ovr_q <= 1'b0;
    end
  end

  // Data-available flag
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_av_q <= 1'b0;
    end else if (!port_on_q) begin
      rx_av_q <= 1'b0;
    end else if (push && count_q + 1'b1 >= TRIG) begin
      rx_av_q <= 1'b1;
    end else if (rxav_arm_q && pop && count_q == 1) begin
      rx_av_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= rx_irq_q && (rx_av_q || ovr_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receive FIFO storage
  always_ff @(posedge clk_i) begin
    if (push) fifo_mem[wr_ptr_q] <= push_word;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (!port_on_q || !rx_on_q) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) wr_ptr_q <= PW'(wr_ptr_q + 1'b1);
      if (pop)  rd_ptr_q <= PW'(rd_ptr_q + 1'b1);
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver
  logic           rx_meta_q, rx_sync_q;
  usc1_rx_state_t rx_st_q;
  logic [15:0]    rx_cnt_q;
  logic [3:0]     rx_idx_q;
  logic [8:0]     rx_sh_q;
  logic [1:0]     rx_smp_q;
  logic           rx_noise_q;
  logic [15:0]    mid;
  logic           maj, unan, rx_act, par_bit_slot;

  assign rx_act   = port_on_q && rx_on_q;
  assign mid      = {1'b0, div_q[15:1]};
  assign maj      = (rx_smp_q[0] & rx_smp_q[1]) |
                    (rx_sync_q & (rx_smp_q[0] | rx_smp_q[1]));
  assign unan     = rx_smp_q[0] == rx_smp_q[1] && rx_smp_q[1] == rx_sync_q;
  assign frame_done = rx_st_q == USC1_RX_STOP && rx_cnt_q == mid + 16'd1;
  assign par_bit_slot = nine_q ? rx_sh_q[8] : rx_sh_q[7];

  assign push       = frame_done && !ovr_q && count_q != FULL;
  assign word_noise = rx_noise_q || !unan;
  assign word_ferr  = !maj;
  assign word_perr  = par_on_q &&
                      par_bit_slot != par_calc(rx_sh_q, nine_q, kind_q);
  always_comb begin
    push_word = rx_sh_q;
    if (par_on_q && nine_q)  push_word[8] = 1'b0;
    if (!nine_q)             push_word[8] = 1'b0;
    if (par_on_q && !nine_q) push_word[7] = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin_i;
      rx_sync_q <= rx_meta_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_st_q    <= USC1_RX_IDLE;
      rx_cnt_q   <= 16'h0000;
      rx_idx_q   <= 4'h0;
      rx_sh_q    <= 9'h000;
      rx_smp_q   <= 2'b11;
      rx_noise_q <= 1'b0;
    end else if (!rx_act) begin
      rx_st_q  <= USC1_RX_IDLE;
      rx_cnt_q <= 16'h0000;
    end else begin
      rx_cnt_q <= (rx_cnt_q == div_q) ? 16'h0000 : rx_cnt_q + 16'd1;
      if (rx_cnt_q == mid - 16'd1) rx_smp_q[0] <= rx_sync_q;
      if (rx_cnt_q == mid)         rx_smp_q[1] <= rx_sync_q;
      case (rx_st_q)
        USC1_RX_IDLE: begin
          rx_cnt_q <= 16'h0000;
          if (!rx_sync_q) begin
            rx_st_q    <= USC1_RX_START;
            rx_noise_q <= 1'b0;
            rx_idx_q   <= 4'h0;
            rx_sh_q    <= 9'h000;
          end
        end
        USC1_RX_START: begin
          if (rx_cnt_q == mid + 16'd1) begin
            if (!unan) rx_noise_q <= 1'b1;
            if (maj) rx_st_q <= USC1_RX_IDLE;
          end else if (rx_cnt_q == div_q) begin
            rx_st_q <= USC1_RX_DATA;
          end
        end
        USC1_RX_DATA: begin
          if (rx_cnt_q == mid + 16'd1) begin
            rx_sh_q[rx_idx_q] <= maj;
            if (!unan) rx_noise_q <= 1'b1;
          end else if (rx_cnt_q == div_q) begin
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q == (nine_q ? 4'd8 : 4'd7))
              rx_st_q <= USC1_RX_STOP;
          end
        end
        USC1_RX_STOP: begin
          if (frame_done) rx_st_q <= USC1_RX_IDLE;
        end
        default: rx_st_q <= USC1_RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_idle_q <= 1'b1;
    end else begin
      rx_idle_q <= !rx_act || rx_st_q == USC1_RX_IDLE && rx_sync_q
                   || frame_done;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmitter
  usc1_tx_state_t tx_st_q;
  logic [15:0]    tx_cnt_q;
  logic [3:0]     tx_idx_q;
  logic [8:0]     hold_q, tx_sh_q;
  logic           hold_full_q, tx_tick, tx_act, tx_on_d1_q, load;
  logic [8:0]     load_word;

  assign tx_act  = port_on_q && tx_on_q;
  assign tx_tick = tx_cnt_q == div_q;
  assign load    = tx_act && tx_st_q == USC1_TX_IDLE && hold_full_q;

  always_comb begin
    load_word = hold_q;
    if (!nine_q) load_word[8] = 1'b0;
    if (par_on_q && nine_q)
      load_word[8] = par_calc(hold_q, 1'b1, kind_q);
    else if (par_on_q)
      load_word[7] = par_calc(hold_q, 1'b0, kind_q);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_q      <= 9'h000;
      hold_full_q <= 1'b0;
    end else if (!tx_act) begin
      hold_full_q <= 1'b0;
    end else if (data_wr) begin
      hold_q      <= {tx9_q, reg_wdata_i};
      hold_full_q <= 1'b1;
    end else if (load) begin
      hold_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_st_q  <= USC1_TX_IDLE;
      tx_cnt_q <= 16'h0000;
      tx_idx_q <= 4'h0;
      tx_sh_q  <= 9'h000;
    end else if (!tx_act) begin
      tx_st_q  <= USC1_TX_IDLE;
      tx_cnt_q <= 16'h0000;
    end else begin
      tx_cnt_q <= tx_tick ? 16'h0000 : tx_cnt_q + 16'd1;
      case (tx_st_q)
        USC1_TX_IDLE: begin
          tx_cnt_q <= 16'h0000;
          tx_idx_q <= 4'h0;
          if (hold_full_q) begin
            tx_sh_q <= load_word;
            tx_st_q <= USC1_TX_START;
          end else if (brk_q) begin
            tx_st_q <= USC1_TX_BREAK;
          end
        end
        USC1_TX_START: if (tx_tick) tx_st_q <= USC1_TX_DATA;
        USC1_TX_DATA: begin
          if (tx_tick) begin
            tx_idx_q <= tx_idx_q + 4'h1;
            if (tx_idx_q == (nine_q ? 4'd8 : 4'd7)) begin
              tx_st_q  <= USC1_TX_STOP;
              tx_idx_q <= 4'h0;
            end
          end
        end
        USC1_TX_STOP: begin
          if (tx_tick) begin
            tx_idx_q <= tx_idx_q + 4'h1;
            if (!stop2_q || tx_idx_q == 4'd1) tx_st_q <= USC1_TX_IDLE;
          end
        end
        USC1_TX_BREAK: begin
          if (tx_tick && tx_idx_q != `USC1_BREAK_BITS)
            tx_idx_q <= tx_idx_q + 4'h1;
          if (tx_idx_q == `USC1_BREAK_BITS && !brk_q)
            tx_st_q <= USC1_TX_IDLE;
        end
        default: tx_st_q <= USC1_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_pin_o    <= 1'b1;
      tx_pin_oe_o <= 1'b0;
    end else begin
      tx_pin_oe_o <= tx_act;
      case (tx_st_q)
        USC1_TX_START: tx_pin_o <= 1'b0;
        USC1_TX_DATA:  tx_pin_o <= tx_sh_q[tx_idx_q];
        USC1_TX_BREAK: tx_pin_o <= 1'b0;
        default:       tx_pin_o <= 1'b1;
      endcase
    end
  end

  // Transmit empty and idle flags; set wins over clear for empty, clear wins for idle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_empty_q <= 1'b1;
      tx_idle_q  <= 1'b1;
      tx_on_d1_q <= 1'b0;
    end else begin
      tx_on_d1_q <= tx_act;
      if (!port_on_q) begin
        tx_empty_q <= 1'b1;
      end else if (load || (tx_act && !tx_on_d1_q)) begin
        tx_empty_q <= 1'b1;
      end else if (tx_arm_q && data_wr) begin
        tx_empty_q <= 1'b0;
      end
      if (!port_on_q) begin
        tx_idle_q <= 1'b1;
      end else if (tx_arm_q && data_wr) begin
        tx_idle_q <= 1'b0;
      end else begin
        tx_idle_q <= tx_empty_q && !hold_full_q && !brk_q &&
                     tx_st_q == USC1_TX_IDLE;
      end
    end
  end

endmodule

//--- testbench/tb_uart_status_and_control_one.sv
// Purpose: Register-level tests of the serial status/control block
// Assumes: Divisor 3, four clocks per bit
// Notes:   Self-checking
`timescale 1ns/1ps
`include "usc1_defines.svh"
module tb_uart_status_and_control_one;
  localparam int BIT = 4;
  localparam int LIMIT = 20000;
  localparam logic [3:0] PAR_OK = 4'b0110;
  logic       clk_i;
  logic       rst_b_i;
  logic       reg_wr_i;
  logic       reg_rd_i;
  logic       rx_line;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] rdata_v;
  logic [7:0] reg_rdata_o;
  logic       tx_pin_o;
  logic       irq_o;
  logic [9:0] frame_v;
  int         failures;
  int         comparisons;
  int         cycles;

  usc1_top #(.FIFO_DEPTH(4), .RX_TRIGGER(1)) i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .rx_pin_i(rx_line), .tx_pin_o(tx_pin_o),
    .tx_pin_oe_o(), .irq_o(irq_o));
  usc1_serial_peer #(.BIT_CLKS(BIT)) i_peer (
    .clk_i(clk_i), .tx_pin_i(tx_pin_o), .line_o(rx_line));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input string n, input logic [9:0] e, logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic rdchk(input string n, input logic [2:0] a, logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(n, {2'b00, e}, {2'b00, v});
  endtask
  task report_and_stop;
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, rst_b_i} = '0;
    {failures, comparisons, cycles} = '0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rdchk("status", `USC1_ADDR_STATUS, 8'h0B);
    rd(`USC1_ADDR_CTRL1, rdata_v);
    chk("ctrl1", 10'h000, {2'b00, rdata_v & 8'hFD});
    wr(`USC1_ADDR_DIVL, 8'h03);
    wr(`USC1_ADDR_DIVH, 8'h00);
    wr(`USC1_ADDR_CTRL1, 8'h80);
    rdchk("status", `USC1_ADDR_STATUS, 8'h0B);
    wr(`USC1_ADDR_DATA, 8'h00);
    rdchk("status", `USC1_ADDR_STATUS, 8'h08);
    wr(`USC1_ADDR_CTRL2, 8'hC4);
    @(posedge clk_i);
    rdchk("status", `USC1_ADDR_STATUS, 8'h0B);
    fork
      begin
        wr(`USC1_ADDR_DATA, 8'hA5);
        rdchk("status", `USC1_ADDR_STATUS, 8'h09);
      end
      i_peer.catch_frame(8, frame_v);
    join
    chk("tx frame", 10'h2A5, frame_v);
    repeat (8) @(posedge clk_i);
    rdchk("status", `USC1_ADDR_STATUS, 8'h0B);
    fork
      i_peer.send(9'h03C, 8, 1'b1);
      begin
        repeat (20) @(posedge clk_i);
        rdchk("status", `USC1_ADDR_STATUS, 8'h03);
      end
    join
    rdchk("status", `USC1_ADDR_STATUS, 8'h0F);
    chk("irq", 10'h001, {9'h000, irq_o});
    rdchk("rx data", `USC1_ADDR_DATA, 8'h3C);
    rdchk("status", `USC1_ADDR_STATUS, 8'h0B);
    for (int k = 0; k < 4; k++) begin
      wr(`USC1_ADDR_CTRL1, {3'b101, 2'(k), 3'b000});
      i_peer.send({1'b0, PAR_OK[k], 7'h03}, 8, 1'b1);
      rdchk("status", `USC1_ADDR_STATUS, 8'h0F);
      rdchk("rx data", `USC1_ADDR_DATA, 8'h03);
    end
    wr(`USC1_ADDR_CTRL1, 8'hA0);
    i_peer.send(9'h083, 8, 1'b1);
    rdchk("status", `USC1_ADDR_STATUS, 8'h8F);
    rdchk("rx data", `USC1_ADDR_DATA, 8'h03);
    rdchk("status", `USC1_ADDR_STATUS, 8'h0B);
    wr(`USC1_ADDR_CTRL1, 8'h80);
    i_peer.send(9'h055, 8, 1'b0);
    rdchk("status", `USC1_ADDR_STATUS, 8'h2F);
    rdchk("rx data", `USC1_ADDR_DATA, 8'h55);
    rdchk("status", `USC1_ADDR_STATUS, 8'h0B);
    wr(`USC1_ADDR_CTRL1, 8'hC0);
    i_peer.send(9'h1A5, 9, 1'b1);
    rdchk("status", `USC1_ADDR_STATUS, 8'h0F);
    rd(`USC1_ADDR_CTRL1, rdata_v);
    chk("ctrl1", 10'h0C2, {2'b00, rdata_v & 8'hFE});
    rdchk("rx data", `USC1_ADDR_DATA, 8'hA5);
    wr(`USC1_ADDR_CTRL1, 8'hC1);
    fork
      wr(`USC1_ADDR_DATA, 8'h5A);
      i_peer.catch_frame(9, frame_v);
    join
    chk("tx frame", 10'h35A, frame_v);
    repeat (8) @(posedge clk_i);
    wr(`USC1_ADDR_CTRL1, 8'h84);
    repeat (4) @(posedge clk_i);
    wr(`USC1_ADDR_CTRL1, 8'h80);
    repeat (13 * BIT - 12) @(posedge clk_i);
    chk("break pin", 10'h000, {9'h000, tx_pin_o});
    repeat (16) @(posedge clk_i);
    chk("break pin", 10'h001, {9'h000, tx_pin_o});
    for (int k = 0; k < 5; k++) i_peer.send(9'(8'h10 + k), 8, 1'b1);
    rdchk("status", `USC1_ADDR_STATUS, 8'h1F);
    chk("irq", 10'h001, {9'h000, irq_o});
    for (int k = 0; k < 4; k++)
      rdchk("rx data", `USC1_ADDR_DATA, 8'(8'h10 + k));
    wr(`USC1_ADDR_CTRL1, 8'h00);
    rdchk("status", `USC1_ADDR_STATUS, 8'h0B);
    rdchk("ctrl2", `USC1_ADDR_CTRL2, 8'h04);
    report_and_stop();
  end
endmodule

//--- testbench/usc1_serial_peer.sv
// Purpose: Far-end serial device on the receive and transmit lines
// Assumes: Bit period of BIT_CLKS clocks, receive line pulled up
// Notes:   Driven and sampled at rising clock edges
`timescale 1ns/1ps
module usc1_serial_peer #(
  parameter int BIT_CLKS = 4
) (
  input  wire logic clk_i,
  input  wire logic tx_pin_i,
  output logic      line_o
);
  initial line_o = 1'b1;

  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Start low, data LSB first, stop, then released high
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    @(posedge clk_i);
    line_o <= 1'b0;
    hold(BIT_CLKS);
    for (int i = 0; i < n; i++) begin
      line_o <= d[i];
      hold(BIT_CLKS);
    end
    line_o <= stp;
    hold(BIT_CLKS);
    line_o <= 1'b1;
    hold(2 * BIT_CLKS);
  endtask

  // Returns {stop, data} sampled mid-bit
  task automatic catch_frame(input int n, output logic [9:0] f);
    f = '0;
    do @(posedge clk_i); while (tx_pin_i !== 1'b0);
    hold(BIT_CLKS / 2 - 1);
    for (int i = 0; i < n; i++) begin
      hold(BIT_CLKS);
      f[i] = tx_pin_i;
    end
    hold(BIT_CLKS);
    f[9] = tx_pin_i;
  endtask
endmodule

//--- testbench/usc1_top_sva.sv
// Purpose: Port-level checks of the serial status/control block
// Assumes: Register helpers mirror control writes
// Notes:   Bound to usc1_top
`timescale 1ns/1ps
`include "usc1_defines.svh"
module usc1_top_chk #(
  parameter int FIFO_DEPTH = 4,
  parameter int RX_TRIGGER = 1
) (
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       tx_pin_o,
  input wire logic       tx_pin_oe_o,
  input wire logic       irq_o
);
  logic [7:3] cfg_q;
  logic       tx_on_q;
  logic       irq_on_q;
  logic       rd_st;
  logic       wr1;
  logic       wr2;
  assign rd_st = reg_rd_i && reg_addr_i == `USC1_ADDR_STATUS;
  assign wr1   = reg_wr_i && reg_addr_i == `USC1_ADDR_CTRL1;
  assign wr2   = reg_wr_i && reg_addr_i == `USC1_ADDR_CTRL2;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) cfg_q <= '0;
    else if (wr1) cfg_q <= reg_wdata_i[7:3];
  end

  // Transmit enable forced off while port off
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_on_q  <= 1'b0;
      irq_on_q <= 1'b0;
    end else if (wr2) begin
      tx_on_q  <= reg_wdata_i[7] & cfg_q[7];
      irq_on_q <= reg_wdata_i[2];
    end else if (wr1 && !reg_wdata_i[7]) begin
      tx_on_q  <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_OE_OFF: assert property (!tx_on_q [*3] |-> !tx_pin_oe_o)
    else $error("tx pin driven while disabled");
  AST_OE_ON: assert property (tx_on_q [*3] |-> tx_pin_oe_o)
    else $error("tx pin floats while enabled");
  AST_IRQ_MASK: assert property (!irq_on_q [*3] |-> !irq_o)
    else $error("irq raised while masked");
  AST_IRQ_AVAIL: assert property (rd_st ##1 (reg_rdata_o[2] &&
    irq_on_q && $past(irq_on_q, 2)) |-> irq_o)
    else $error("irq missing with data available");
  AST_OFF_STATUS: assert property (!cfg_q[7] [*2] ##0 rd_st |=>
    reg_rdata_o == `USC1_STATUS_RST)
    else $error("status wrong while port off");
  AST_CFG_RB: assert property (wr1 == 1'b0 && reg_rd_i &&
    reg_addr_i == `USC1_ADDR_CTRL1 |=> reg_rdata_o[7:3] == cfg_q)
    else $error("control one readback wrong");
  AST_TXIDLE_PIN: assert property (rd_st ##1 reg_rdata_o[1]
    |-> tx_pin_o)
    else $error("tx pin low while idle");
  AST_RDATA_HOLD: assert property (!$past(reg_rd_i) |->
    $stable(reg_rdata_o))
    else $error("read data changed without read");

  cover property ($fell(tx_pin_o));
  cover property ($rose(irq_o));
  cover property (rd_st ##1 reg_rdata_o[4]);
endmodule

bind usc1_top usc1_top_chk #(
  .FIFO_DEPTH(FIFO_DEPTH),
  .RX_TRIGGER(RX_TRIGGER)
) i_chk (
  .clk_i      (clk_i),
  .rst_b_i    (rst_b_i),
  .reg_addr_i (reg_addr_i),
  .reg_wr_i   (reg_wr_i),
  .reg_rd_i   (reg_rd_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .tx_pin_o   (tx_pin_o),
  .tx_pin_oe_o(tx_pin_oe_o),
  .irq_o      (irq_o)
);
